// >>> design/page_buf_if.sv
// Connection between the sequencer and the temporary page buffer
`timescale 1ns/1ps
interface page_buf_if;
  import spm_pkg::*;
  logic              wr_en;
  logic [WORD_W-1:0] wr_idx;
  logic [DATA_W-1:0] wr_data;
  logic              clr;
  logic [WORD_W-1:0] rd_idx;
  logic [DATA_W-1:0] rd_data;

  modport owner (output wr_en, wr_idx, wr_data, clr, rd_idx, input rd_data);
  modport store (input wr_en, wr_idx, wr_data, clr, rd_idx, output rd_data);
endinterface

// >>> design/self_program_flash_control.sv
// Self-programming sequencer, fuse and lock store, and control register
//
// Functional notes
// - Control bits 7 and 5 are reserved and always read zero.
// - Section busy flag at bit 6 always reads zero.
// - Writing the buffer clear command empties the whole temporary page buffer.
// - Load within three cycles of fuse read arming returns byte picked by Z.
// - Page write command plus store writes buffer to page from upper Z.
// - Page write bit clears on completion or after four idle cycles.
// - CPU stays halted for the whole page erase or page write.
// - Page erase command plus store erases page addressed by upper Z.
// - Page erase bit clears on completion or after four idle cycles.
// - Self program enable permits a store only for the next four cycles.
// - Plain enable then store puts R1:R0 into buffer word picked by Z.
// - Enable clears after a store or four idle cycles, held during operations.
// - Only five lower-bit patterns are acted upon; others have no effect.
// - Two lock bits, one is unprogrammed, reset to one only by chip erase.
// - Stores are enabled only when the self program fuse is programmed.
// - Lock mode two blocks flash and EEPROM programming and locks fuses.
// - Lock mode three also blocks verification, and locks fuses.
// - Extended fuse byte: bit 0 self program enable, all defaults one.
// - High fuse byte fields and defaults; only serial download defaults to zero.
// - Chip erase keeps fuses; fuses frozen once lock bit one is programmed.
// - Fuses latched at power-up and programming entry; EEPROM preserve acts at once.
// - Z value 0 low, 1 lock, 2 extended, 3 high selects the read byte.
// - EEPROM write in progress blocks flash programming and fuse reads.
`timescale 1ns/1ps
module self_program_flash_control
  import spm_pkg::*;
#(
  parameter int OP_LEN = OP_CYCLES
) (
  input  wire logic              clk_sys_i,
  input  wire logic              nrst_i,
  input  wire logic [7:0]        io_addr_i,
  input  wire logic              io_wr_i,
  input  wire logic              io_rd_i,
  input  wire logic [7:0]        io_wdata_i,
  output logic      [7:0]        ctrl_rdata_o,
  input  wire logic              spm_exec_i,
  input  wire logic              lpm_exec_i,
  input  wire logic [15:0]       z_ptr_i,
  input  wire logic [15:0]       r1r0_i,
  input  wire logic              eeprom_write_in_progress_i,
  output logic      [7:0]        lpm_data_o,
  output logic                   lpm_valid_o,
  output logic                   cpu_halt_o,
  output logic                   flash_erase_o,
  output logic                   flash_write_o,
  output logic      [PAGE_W-1:0] flash_page_o,
  input  wire logic [WORD_W-1:0] flash_rd_idx_i,
  output logic      [DATA_W-1:0] flash_rd_data_o,
  input  wire logic              prog_mode_i,
  input  wire logic              fuse_wr_i,
  input  wire logic [1:0]        fuse_sel_i,
  input  wire logic [7:0]        fuse_wdata_i,
  input  wire logic              lock_wr_i,
  input  wire logic [7:0]        lock_wdata_i,
  input  wire logic              chip_erase_i,
  output logic      [7:0]        fuse_low_o,
  output logic      [7:0]        fuse_high_o,
  output logic      [7:0]        fuse_ext_o,
  output logic                   eeprom_preserve_fuse_o,
  output logic                   flash_prog_block_o,
  output logic                   flash_verify_block_o,
  output logic                   fuse_locked_o
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_BUSY
  } seq_state_t;

  page_buf_if buf_if ();

  seq_state_t          st;
  seq_state_t          next_st;
  logic [CMD_W-1:0]    cmd;
  logic [CMD_W-1:0]    next_cmd;
  logic [2:0]          win;
  logic [2:0]          next_win;
  logic [7:0]          next_ctrl_rdata;
  logic [7:0]          next_lpm_data;
  logic                next_lpm_valid;
  logic                next_halt;
  logic                next_erase;
  logic                next_write;
  logic [PAGE_W-1:0]   next_page;
  logic                timer_start;
  logic                timer_busy;
  logic                timer_done;
  logic                ctrl_wr;
  logic                cmd_legal;
  logic                spm_allowed;

  logic [7:0]          lock_byte;
  logic [7:0]          fuse_ext;
  logic [7:0]          fuse_high;
  logic [7:0]          fuse_low;
  logic [7:0]          next_lock_byte;
  logic [7:0]          next_fuse_ext;
  logic [7:0]          next_fuse_high;
  logic [7:0]          next_fuse_low;
  logic [7:0]          next_fuse_ext_o;
  logic [7:0]          next_fuse_high_o;
  logic [7:0]          next_fuse_low_o;
  logic                latch_pending;
  logic                prog_mode_q;
  logic                next_prog_mode_q;
  logic                fuse_wr_ok;
  logic                next_prog_block;
  logic                next_verify_block;
  logic                next_fuse_locked;

  spm_page_buffer u_buffer (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .buf_if    (buf_if.store)
  );

  spm_op_timer #(
    .CYCLES (OP_LEN)
  ) u_timer (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .start_i   (timer_start),
    .busy_o    (timer_busy),
    .done_o    (timer_done)
  );

  // Latched fuse copy governs stores, so a fuse change waits for latching
  assign spm_allowed = (fuse_ext_o[EXT_SELF_PROG] == 1'b0);
  assign ctrl_wr     = io_wr_i && (io_addr_i == CTRL_ADDR);
  assign cmd_legal   = (io_wdata_i[CMD_W-1:0] == CMD_STORE) ||
                       (io_wdata_i[CMD_W-1:0] == CMD_ERASE) ||
                       (io_wdata_i[CMD_W-1:0] == CMD_WRITE) ||
                       (io_wdata_i[CMD_W-1:0] == CMD_FUSE_READ) ||
                       (io_wdata_i[CMD_W-1:0] == CMD_CLEAR);

  assign buf_if.rd_idx  = flash_rd_idx_i;
  assign buf_if.wr_idx  = z_ptr_i[WORD_LSB +: WORD_W];
  assign buf_if.wr_data = r1r0_i;

  // Sequencer
  always_comb begin
    next_st         = st;
    next_cmd        = cmd;
    next_win        = win;
    next_lpm_data   = lpm_data_o;
    next_lpm_valid  = 1'b0;
    next_halt       = cpu_halt_o;
    next_erase      = 1'b0;
    next_write      = 1'b0;
    next_page       = flash_page_o;
    timer_start     = 1'b0;
    buf_if.wr_en    = 1'b0;
    buf_if.clr      = 1'b0;
    case (st)
      ST_IDLE: begin
        // Illegal patterns and blocked writes leave everything untouched
        if (ctrl_wr && cmd_legal && spm_allowed && !eeprom_write_in_progress_i) begin
          next_cmd = io_wdata_i[CMD_W-1:0];
          next_win = SPM_WINDOW;
          next_st  = ST_ARMED;
          if (io_wdata_i[CMD_W-1:0] == CMD_CLEAR) begin
            buf_if.clr = 1'b1;
          end
        end
        // A store here finds no armed command and does nothing
      end
      ST_ARMED: begin
        next_win = win - 1'b1;
        if (spm_exec_i && !eeprom_write_in_progress_i) begin
          next_cmd = CMD_NONE;
          next_st  = ST_IDLE;
          case (cmd)
            CMD_STORE: begin
              buf_if.wr_en = 1'b1;
            end
            CMD_ERASE, CMD_WRITE: begin
              // Bits stay set until the timer ends the operation
              next_cmd    = cmd;
              next_st     = ST_BUSY;
              next_halt   = 1'b1;
              timer_start = 1'b1;
              next_erase  = (cmd == CMD_ERASE);
              next_write  = (cmd == CMD_WRITE);
              next_page   = z_ptr_i[PAGE_LSB +: PAGE_W];
            end
            default: begin
              next_cmd = CMD_NONE;
            end
          endcase
        end else if (lpm_exec_i && (cmd == CMD_FUSE_READ) && (win > (SPM_WINDOW - LPM_WINDOW))
                     && !eeprom_write_in_progress_i) begin
          next_lpm_valid = 1'b1;
          next_cmd       = CMD_NONE;
          next_st        = ST_IDLE;
          case (z_ptr_i[1:0])
            SEL_FUSE_LOW:  next_lpm_data = fuse_low_o;
            SEL_LOCK:      next_lpm_data = lock_byte;
            SEL_FUSE_EXT:  next_lpm_data = fuse_ext_o;
            SEL_FUSE_HIGH: next_lpm_data = fuse_high_o;
            default:       next_lpm_data = fuse_low_o;
          endcase
        end else if (win == 3'h1) begin
          // Window expired without a store, all command bits drop
          next_cmd = CMD_NONE;
          next_st  = ST_IDLE;
        end
      end
      ST_BUSY: begin
        next_win = WIN_ZERO;
        if (timer_done) begin
          next_cmd  = CMD_NONE;
          next_halt = 1'b0;
          next_st   = ST_IDLE;
        end
      end
      default: begin
        next_st  = ST_IDLE;
        next_cmd = CMD_NONE;
      end
    endcase
  end

  // Register read: reserved and busy bits are constant zero
  always_comb begin
    next_ctrl_rdata = ctrl_rdata_o;
    if (io_rd_i && (io_addr_i == CTRL_ADDR)) begin
      next_ctrl_rdata = {3'h0, cmd};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      st              <= ST_IDLE;
      cmd             <= CTRL_RESET[CMD_W-1:0];
      win             <= WIN_ZERO;
      ctrl_rdata_o    <= CTRL_RESET;
      lpm_data_o      <= 8'h00;
      lpm_valid_o     <= 1'b0;
      cpu_halt_o      <= 1'b0;
      flash_erase_o   <= 1'b0;
      flash_write_o   <= 1'b0;
      flash_page_o    <= '0;
      flash_rd_data_o <= '0;
    end else begin
      st              <= next_st;
      cmd             <= next_cmd;
      win             <= next_win;
      ctrl_rdata_o    <= next_ctrl_rdata;
      lpm_data_o      <= next_lpm_data;
      lpm_valid_o     <= next_lpm_valid;
      cpu_halt_o      <= next_halt;
      flash_erase_o   <= next_erase;
      flash_write_o   <= next_write;
      flash_page_o    <= next_page;
      flash_rd_data_o <= buf_if.rd_data;
    end
  end

  // Fuse and lock store; reset stands in for a blank part
  assign fuse_wr_ok = prog_mode_i && lock_byte[LOCK_BIT_ONE];

  always_comb begin
    next_lock_byte    = lock_byte;
    next_fuse_ext     = fuse_ext;
    next_fuse_high    = fuse_high;
    next_fuse_low     = fuse_low;
    next_prog_mode_q  = prog_mode_i;
    next_fuse_ext_o   = fuse_ext_o;
    next_fuse_high_o  = fuse_high_o;
    next_fuse_low_o   = fuse_low_o;
    if (prog_mode_i && chip_erase_i) begin
      next_lock_byte = LOCK_DEFAULT;
    end else if (prog_mode_i && lock_wr_i) begin
      // Lock bits can only move toward programmed
      next_lock_byte = lock_byte & lock_wdata_i;
    end
    if (fuse_wr_ok && fuse_wr_i) begin
      case (fuse_sel_i)
        SEL_FUSE_LOW:  next_fuse_low  = fuse_wdata_i;
        SEL_FUSE_HIGH: next_fuse_high = fuse_wdata_i;
        SEL_FUSE_EXT:  next_fuse_ext  = fuse_wdata_i;
        default:       next_fuse_low  = fuse_low;
      endcase
    end
    // Latch after reset release and on entry to programming mode
    if (latch_pending || (prog_mode_i && !prog_mode_q)) begin
      next_fuse_ext_o  = fuse_ext;
      next_fuse_high_o = fuse_high;
      next_fuse_low_o  = fuse_low;
    end
    next_fuse_locked  = (next_lock_byte[LOCK_BIT_ONE] == 1'b0);
    next_prog_block   = (next_lock_byte[LOCK_BIT_ONE] == 1'b0);
    next_verify_block = (next_lock_byte[LOCK_BIT_ONE] == 1'b0) &&
                        (next_lock_byte[LOCK_BIT_TWO] == 1'b0);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      lock_byte              <= LOCK_DEFAULT;
      fuse_ext               <= EXT_DEFAULT;
      fuse_high              <= HIGH_DEFAULT;
      fuse_low               <= LOW_DEFAULT;
      fuse_ext_o             <= EXT_DEFAULT;
      fuse_high_o            <= HIGH_DEFAULT;
      fuse_low_o             <= LOW_DEFAULT;
      latch_pending          <= 1'b1;
      prog_mode_q            <= 1'b0;
      eeprom_preserve_fuse_o <= HIGH_DEFAULT[HIGH_EEPROM_PRESERVE_FUSE];
      flash_prog_block_o     <= 1'b0;
      flash_verify_block_o   <= 1'b0;
      fuse_locked_o          <= 1'b0;
    end else begin
      lock_byte              <= next_lock_byte;
      fuse_ext               <= next_fuse_ext;
      fuse_high              <= next_fuse_high;
      fuse_low               <= next_fuse_low;
      fuse_ext_o             <= next_fuse_ext_o;
      fuse_high_o            <= next_fuse_high_o;
      fuse_low_o             <= next_fuse_low_o;
      latch_pending          <= 1'b0;
      prog_mode_q            <= next_prog_mode_q;
      // Preserve fuse bypasses the latch and acts as soon as stored
      eeprom_preserve_fuse_o <= next_fuse_high[HIGH_EEPROM_PRESERVE_FUSE];
      flash_prog_block_o     <= next_prog_block;
      flash_verify_block_o   <= next_verify_block;
      fuse_locked_o          <= next_fuse_locked;
    end
  end

endmodule // self_program_flash_control

// >>> design/spm_op_timer.sv
// Duration counter for page erase and page write
`timescale 1ns/1ps
module spm_op_timer
  import spm_pkg::*;
#(
  parameter int CYCLES = OP_CYCLES
) (
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  input  wire logic start_i,
  output logic      busy_o,
  output logic      done_o
);

  logic [OP_CNT_W-1:0] cnt;
  logic [OP_CNT_W-1:0] next_cnt;
  logic                next_busy;
  logic                next_done;

  always_comb begin
    next_cnt  = cnt;
    next_busy = busy_o;
    next_done = 1'b0;
    if (!busy_o && start_i) begin
      next_cnt  = OP_CNT_W'(CYCLES - 1);
      next_busy = 1'b1;
    end else if (busy_o) begin
      if (cnt == '0) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_cnt = cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      cnt    <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      busy_o <= next_busy;
      done_o <= next_done;
    end
  end

endmodule // spm_op_timer

// >>> design/spm_page_buffer.sv
// Temporary page buffer held in flip-flops
`timescale 1ns/1ps
module spm_page_buffer
  import spm_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  page_buf_if.store buf_if
);

  logic [DATA_W-1:0] mem      [BUF_DEPTH];
  logic [DATA_W-1:0] next_mem [BUF_DEPTH];

  genvar g;
  generate
    for (g = 0; g < BUF_DEPTH; g++) begin : g_entry
      always_comb begin
        next_mem[g] = mem[g];
        if (buf_if.clr) begin
          next_mem[g] = 16'hFFFF;
        end else if (buf_if.wr_en && (buf_if.wr_idx == WORD_W'(g))) begin
          next_mem[g] = buf_if.wr_data;
        end
      end

      always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
          mem[g] <= 16'hFFFF;
        end else begin
          mem[g] <= next_mem[g];
        end
      end
    end
  endgenerate

  assign buf_if.rd_data = mem[buf_if.rd_idx];

endmodule // spm_page_buffer

// >>> design/spm_pkg.sv
// Shared constants for the self-programming flash control block
package spm_pkg;

  // Control and status register placement and fields
  localparam logic [7:0] CTRL_ADDR       = 8'h37;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam int         BIT_SPMEN       = 0;
  localparam int         BIT_PAGE_ERASE_CMD       = 1;
  localparam int         BIT_PAGE_WRITE_CMD       = 2;
  localparam int         BIT_FUSE_LOCK_READ        = 3;
  localparam int         BIT_PAGE_BUFFER_CLEAR        = 4;
  localparam int         CMD_W           = 5;

  // Accepted patterns of the lower five control bits
  localparam logic [4:0] CMD_STORE       = 5'h01;
  localparam logic [4:0] CMD_ERASE       = 5'h03;
  localparam logic [4:0] CMD_WRITE       = 5'h05;
  localparam logic [4:0] CMD_FUSE_READ   = 5'h09;
  localparam logic [4:0] CMD_CLEAR       = 5'h11;
  localparam logic [4:0] CMD_NONE        = 5'h00;

  // Arming windows in cycles
  localparam logic [2:0] SPM_WINDOW      = 3'h4;
  localparam logic [2:0] LPM_WINDOW      = 3'h3;
  localparam logic [2:0] WIN_ZERO        = 3'h0;

  // Fuse and lock bytes, defaults and field positions
  localparam logic [7:0] LOCK_DEFAULT    = 8'hFF;
  localparam logic [7:0] EXT_DEFAULT     = 8'hFF;
  localparam logic [7:0] HIGH_DEFAULT    = 8'hDF;
  localparam logic [7:0] LOW_DEFAULT     = 8'h6E;
  localparam int         LOCK_BIT_ONE    = 0;
  localparam int         LOCK_BIT_TWO    = 1;
  localparam int         EXT_SELF_PROG   = 0;
  localparam int         HIGH_EEPROM_PRESERVE_FUSE     = 3;

  // Z pointer selection of the byte returned by a fuse read
  localparam logic [1:0] SEL_FUSE_LOW    = 2'h0;
  localparam logic [1:0] SEL_LOCK        = 2'h1;
  localparam logic [1:0] SEL_FUSE_EXT    = 2'h2;
  localparam logic [1:0] SEL_FUSE_HIGH   = 2'h3;

  // Page addressing from the byte-wise Z pointer
  localparam int         WORD_LSB        = 1;
  localparam int         WORD_W          = 5;
  localparam int         PAGE_LSB        = 6;
  localparam int         PAGE_W          = 7;
  localparam int         BUF_DEPTH       = 32;
  localparam int         DATA_W          = 16;

  // Erase and write duration
  localparam int         OP_TIME_NS      = 3700000;
  localparam int         CLK_PERIOD_NS   = 25;
  localparam int         OP_CYCLES       = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         OP_CNT_W        = 18;

endpackage

// >>> testbench/cpu_core_model.sv
// CPU core model: I/O, store and load cycles
`timescale 1ns/1ps
module cpu_core_model (
  input  wire logic        clk_sys_i,
  input  wire logic [7:0]  ctrl_rdata_i,
  output logic      [7:0]  io_addr_o,
  output logic             io_wr_o,
  output logic             io_rd_o,
  output logic      [7:0]  io_wdata_o,
  output logic             spm_o,
  output logic             lpm_o,
  output logic      [15:0] z_o,
  output logic      [15:0] r1r0_o
);
  initial {io_addr_o, io_wr_o, io_rd_o, io_wdata_o, spm_o, lpm_o, z_o, r1r0_o} = '0;
  // Enter at a rising edge; released lines show inverse
  task automatic io_write(input logic [7:0] d);
    io_addr_o <= 8'h37;
    io_wdata_o <= d;
    io_wr_o <= 1'b1;
    @(posedge clk_sys_i);
    io_wr_o <= 1'b0;
    io_wdata_o <= ~d;
  endtask
  task automatic io_read(output logic [7:0] v);
    io_addr_o <= 8'h37;
    io_rd_o <= 1'b1;
    @(posedge clk_sys_i);
    io_rd_o <= 1'b0;
    #1 v = ctrl_rdata_i;
    @(posedge clk_sys_i);
  endtask
  task automatic op(input logic ld, input logic [15:0] z, input logic [15:0] w);
    z_o <= z;
    r1r0_o <= w;
    spm_o <= !ld;
    lpm_o <= ld;
    @(posedge clk_sys_i);
    {spm_o, lpm_o} <= 2'h0;
    z_o <= ~z;
    r1r0_o <= ~w;
  endtask
endmodule // cpu_core_model

// >>> testbench/spm_flash_chk.sv
// Concurrent checks on the control block ports
`timescale 1ns/1ps
module spm_flash_chk #(
  parameter int OP_LEN = 20
) (
  input wire logic       clk_sys_i,
  input wire logic       nrst_i,
  input wire logic [7:0] io_addr_i,
  input wire logic       io_rd_i,
  input wire logic [7:0] ctrl_rdata_o,
  input wire logic       spm_exec_i,
  input wire logic       lpm_exec_i,
  input wire logic       eeprom_write_in_progress_i,
  input wire logic       lpm_valid_o,
  input wire logic       cpu_halt_o,
  input wire logic       flash_erase_o,
  input wire logic       flash_write_o,
  input wire logic       flash_prog_block_o,
  input wire logic       flash_verify_block_o,
  input wire logic       fuse_locked_o,
  input wire logic       fuse_wr_i,
  input wire logic       eeprom_preserve_fuse_o
);
  logic [31:0] hcnt, next_hcnt;
  // Counter, as a repetition cannot span the op
  always_comb next_hcnt = cpu_halt_o ? hcnt + 32'h1 : 32'h0;
  always_ff @(posedge clk_sys_i) hcnt <= nrst_i ? next_hcnt : 32'h0;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  a_rsvd_read_zero: assert property (ctrl_rdata_o[7:5] == 3'h0)
    else $error("reserved control bits read nonzero");
  a_erase_cause: assert property (flash_erase_o |->
    $past(spm_exec_i) && !$past(eeprom_write_in_progress_i) && cpu_halt_o)
    else $error("erase start without store");
  a_write_cause: assert property (flash_write_o |->
    $past(spm_exec_i) && !$past(eeprom_write_in_progress_i) && cpu_halt_o)
    else $error("write start without store");
  a_start_single: assert property ((flash_erase_o || flash_write_o) |=>
    (!flash_erase_o && !flash_write_o) [*8])
    else $error("operation restarted while busy");
  a_halt_length: assert property ($fell(cpu_halt_o) |-> hcnt == 32'(OP_LEN + 1))
    else $error("halt length wrong");
  a_halt_start: assert property ($rose(cpu_halt_o) |-> flash_erase_o || flash_write_o)
    else $error("halt without operation");
  a_busy_bits: assert property (cpu_halt_o && io_rd_i && io_addr_i == 8'h37 |=>
    ctrl_rdata_o[0] && (ctrl_rdata_o[1] ^ ctrl_rdata_o[2]))
    else $error("command bits dropped while busy");
  a_lpm_cause: assert property (lpm_valid_o |->
    $past(lpm_exec_i) && !$past(eeprom_write_in_progress_i))
    else $error("fuse read answer without load");
  a_lock_modes: assert property (flash_verify_block_o |->
    flash_prog_block_o && fuse_locked_o)
    else $error("verify block without program block");
  a_fuse_frozen: assert property (fuse_locked_o && fuse_wr_i |=>
    $stable(eeprom_preserve_fuse_o) [*2])
    else $error("locked fuse changed");
endmodule // spm_flash_chk

bind self_program_flash_control spm_flash_chk #(.OP_LEN(OP_LEN)) i_chk (.*);

// >>> testbench/tb_self_program_flash_control.sv
// Bench for the self-programming control block
`timescale 1ns/1ps
module tb_self_program_flash_control;
  import spm_pkg::*;
  localparam int OPL = 20;
  logic        clk_sys_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [7:0]  io_addr_i, io_wdata_i, ctrl_rdata_o, lpm_data_o;
  logic        io_wr_i, io_rd_i, spm_exec_i, lpm_exec_i, lpm_valid_o, cpu_halt_o;
  logic        flash_erase_o, flash_write_o, flash_prog_block_o, flash_verify_block_o;
  logic        fuse_locked_o, eeprom_preserve_fuse_o;
  logic [15:0] z_ptr_i, r1r0_i, flash_rd_data_o;
  logic [6:0]  flash_page_o;
  logic [7:0]  fuse_low_o, fuse_high_o, fuse_ext_o;
  logic [7:0]  fuse_wdata_i, lock_wdata_i;
  logic [4:0]  flash_rd_idx_i;
  logic [1:0]  fuse_sel_i;
  logic        eeprom_write_in_progress_i, prog_mode_i, fuse_wr_i, lock_wr_i, chip_erase_i;
  int          n_errors = 0, check_count = 0;
  logic [31:0] seed = 32'hB35D3D27;
  logic [7:0]  corner [8] = '{8'hE1, 8'h41, 8'h11, 8'h09, 8'h03, 8'h05, 8'h07, 8'h10};
  logic [7:0]  fz_e [4] = '{8'h6E, 8'hFF, 8'hFE, 8'hD7};

  always #12.5 clk_sys_i = ~clk_sys_i;

  self_program_flash_control #(.OP_LEN(OPL)) i_dut (
    .clk_sys_i, .nrst_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i, .ctrl_rdata_o,
    .spm_exec_i, .lpm_exec_i, .z_ptr_i, .r1r0_i, .eeprom_write_in_progress_i, .lpm_data_o,
    .lpm_valid_o, .cpu_halt_o, .flash_erase_o, .flash_write_o, .flash_page_o,
    .flash_rd_idx_i, .flash_rd_data_o, .prog_mode_i, .fuse_wr_i, .fuse_sel_i, .fuse_wdata_i,
    .lock_wr_i, .lock_wdata_i, .chip_erase_i, .fuse_low_o, .fuse_high_o, .fuse_ext_o,
    .eeprom_preserve_fuse_o, .flash_prog_block_o, .flash_verify_block_o, .fuse_locked_o
  );
  cpu_core_model i_cpu (
    .clk_sys_i, .ctrl_rdata_i(ctrl_rdata_o), .io_addr_o(io_addr_i), .io_wr_o(io_wr_i),
    .io_rd_o(io_rd_i), .io_wdata_o(io_wdata_i), .spm_o(spm_exec_i), .lpm_o(lpm_exec_i),
    .z_o(z_ptr_i), .r1r0_o(r1r0_i)
  );

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] exp_cmd(input logic [7:0] d);
    return (d[4:0] inside {5'h01, 5'h03, 5'h05, 5'h09, 5'h11}) ? {3'h0, d[4:0]} : 8'h00;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic ed(input int n = 1);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic rdc(input logic [7:0] e);
    logic [7:0] v;
    i_cpu.io_read(v);
    chk("ctrl", e, v);
  endtask
  task automatic rdbuf(input logic [4:0] idx, input logic [15:0] e);
    flash_rd_idx_i <= idx;
    ed();
    #1 chk("buf", e, flash_rd_data_o);
    ed();
  endtask
  // Programming strobe
  task automatic prg(input int k, input logic [1:0] s, input logic [7:0] d);
    fuse_sel_i <= s;
    fuse_wdata_i <= d;
    lock_wdata_i <= d;
    {fuse_wr_i, lock_wr_i, chip_erase_i} <= {k == 0, k == 1, k == 2};
    ed();
    {fuse_wr_i, lock_wr_i, chip_erase_i} <= 3'h0;
    ed();
    #1;
  endtask

  initial begin
    logic [31:0] r;
    logic [7:0] d;
    {fuse_wdata_i, lock_wdata_i, flash_rd_idx_i, fuse_sel_i, prog_mode_i} <= '0;
    {eeprom_write_in_progress_i, fuse_wr_i, lock_wr_i, chip_erase_i} <= '0;
    ed(6);
    nrst_i <= 1'b1;
    ed();
    #1 chk("fuse_low", 8'h6E, fuse_low_o);
    chk("fuse_high", 8'hDF, fuse_high_o);
    chk("fuse_ext", 8'hFF, fuse_ext_o);
    chk("prog_block", 1'b0, flash_prog_block_o);
    ed();
    i_cpu.io_write(8'h01);
    rdc(8'h00);
    $display("test reset done");
    prog_mode_i <= 1'b1;
    ed(2);
    prg(0, 2'h2, 8'hFE);
    chk("ext_held", 8'hFF, fuse_ext_o);
    ed();
    prg(0, 2'h3, 8'hD7);
    chk("preserve", 1'b0, eeprom_preserve_fuse_o);
    ed();
    // Re-entry latches new fuses
    prog_mode_i <= 1'b0;
    ed(2);
    prog_mode_i <= 1'b1;
    ed(3);
    prog_mode_i <= 1'b0;
    ed(2);
    #1 chk("ext_latched", 8'hFE, fuse_ext_o);
    chk("high_latched", 8'hD7, fuse_high_o);
    ed();
    $display("test fuse done");
    for (int i = 0; i < 16; i++) begin
      r = xs();
      d = (i < 8) ? corner[i] : r[7:0];
      i_cpu.io_write(d);
      rdc(exp_cmd(d));
      ed(3);
      rdc(8'h00);
    end
    $display("test command done");
    for (int i = 0; i < 6; i++) begin
      r = xs();
      i_cpu.io_write(8'h01);
      i_cpu.op(1'b0, r[15:0], r[31:16]);
      ed();
      i_cpu.op(1'b0, r[15:0], ~r[31:16]);
      rdbuf(r[5:1], r[31:16]);
    end
    i_cpu.io_write(8'h11);
    ed();
    rdbuf(r[5:1], 16'hFFFF);
    ed(4);
    $display("test buffer done");
    // Erase at first window edge, write at last
    for (int k = 0; k < 2; k++) begin
      r = xs();
      i_cpu.io_write(k ? 8'h05 : 8'h03);
      ed(k * 3);
      i_cpu.op(1'b0, r[15:0], r[31:16]);
      #1 chk("start", 1'b1, k ? flash_write_o : flash_erase_o);
      chk("halt", 1'b1, cpu_halt_o);
      chk("page", r[12:6], flash_page_o);
      ed();
      rdc(k ? 8'h05 : 8'h03);
      for (int i = 0; i < OPL + 8; i++) begin
        ed();
        #1;
        if (cpu_halt_o === 1'b0) break;
      end
      if (cpu_halt_o !== 1'b0) begin
        n_errors++;
        wrap_up();
      end
      ed();
      rdc(8'h00);
    end
    i_cpu.io_write(8'h03);
    ed(4);
    i_cpu.op(1'b0, 16'h0FC0, 16'h0000);
    #1 chk("late_erase", 1'b0, flash_erase_o | cpu_halt_o);
    ed();
    $display("test page done");
    for (int s = 0; s < 4; s++) begin
      i_cpu.io_write(8'h09);
      ed(s % 3);
      i_cpu.op(1'b1, 16'(s), 16'h0000);
      #1 chk("lpm_valid", 1'b1, lpm_valid_o);
      chk("lpm_data", fz_e[s], lpm_data_o);
      ed(5);
    end
    eeprom_write_in_progress_i <= 1'b1;
    i_cpu.io_write(8'h01);
    rdc(8'h00);
    eeprom_write_in_progress_i <= 1'b0;
    i_cpu.io_write(8'h09);
    eeprom_write_in_progress_i <= 1'b1;
    i_cpu.op(1'b1, 16'h0001, 16'h0000);
    #1 chk("lpm_blocked", 1'b0, lpm_valid_o);
    ed();
    eeprom_write_in_progress_i <= 1'b0;
    ed(4);
    $display("test read done");
    prog_mode_i <= 1'b1;
    ed(2);
    prg(1, 2'h0, 8'hFE);
    chk("mode2", 2'h1, {flash_verify_block_o, flash_prog_block_o});
    chk("fuse_lock", 1'b1, fuse_locked_o);
    ed();
    prg(0, 2'h3, 8'hFF);
    chk("frozen", 1'b0, eeprom_preserve_fuse_o);
    ed();
    prg(1, 2'h0, 8'hFD);
    chk("mode3", 2'h3, {flash_verify_block_o, flash_prog_block_o});
    ed();
    prg(2, 2'h0, 8'h00);
    chk("unlock", 2'h0, {flash_verify_block_o, flash_prog_block_o});
    chk("kept", 1'b0, eeprom_preserve_fuse_o);
    ed();
    prog_mode_i <= 1'b0;
    ed(2);
    $display("test lock done");
    wrap_up();
  end
endmodule // tb_self_program_flash_control
